/* hdl/mia_arbiter.sv */
`default_nettype none

module mia_arbiter import mia_pkg::*; (
  input  wire logic [N_SRC-1:0] pend_i,
  input  wire logic [N_SRC-1:0] lvl_lo_i,
  input  wire logic [N_SRC-1:0] lvl_hi_i,
  output logic                  valid_o,
  output logic [IDX_W-1:0]      idx_o,
  output logic [1:0]            lvl_o
);

  // ==========================================================
  // Level 0 is best; scanning downward lets low indices win ties
  always_comb begin
    valid_o = 1'b0;
    idx_o   = '0;
    lvl_o   = ISP_IDLE;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (pend_i[i] && (!valid_o || ({lvl_hi_i[i], lvl_lo_i[i]} <= lvl_o))) begin
        valid_o = 1'b1;
        idx_o   = IDX_W'(i);
        lvl_o   = {lvl_hi_i[i], lvl_lo_i[i]};
      end
    end
  end

endmodule

`default_nettype wire

/* hdl/mia_counter.sv */
`default_nettype none

module mia_counter import mia_pkg::*; #(
  parameter int W = CNT_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clr_i,
  input  wire logic         en_i,
  output logic [W-1:0]      cnt_o
);

  // ==========================================================
  // Saturating up counter, so a long stall never wraps to zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_o <= '0;
    end else if (clr_i) begin
      cnt_o <= '0;
    end else if (en_i && (cnt_o != {W{1'b1}})) begin
      cnt_o <= cnt_o + W'(1);
    end
  end

endmodule

`default_nettype wire

/* hdl/mia_pkg.sv */
// Function
// - A source is a candidate only while its request is 1 and mask is 0.
// - Vectored acceptance only while the global interrupt enable is 1.
// - While a higher level is in service, lower level requests are not accepted.
// - Request to start of vectored servicing takes 9 to 14 clocks.
// - A subroutine return in progress may stretch acceptance past the maximum.
// - Among simultaneous requests, the best programmed priority level wins.
// - On equal level, the lowest source index (default order) wins.
// - Blocked requests stay pending and are taken once all conditions hold.
// - On acceptance, the status word is pushed first, the program counter second.
// - On acceptance, enable clears and the source level goes to in-service flags.
// - After stacking, load the source's vector table entry into the program counter.
// - A return-from-interrupt instruction restores the saved status word.
// - After stop release, wait 10 clocks if vectoring follows, else 5.
// - Short stabilization selections still keep the core halted for 61 us.
`default_nettype none

package mia_pkg;

  // ==========================================================
  // Widths
  localparam int N_SRC     = 8;
  localparam int IDX_W     = 3;
  localparam int DW        = 8;
  localparam int AW        = 4;
  localparam int CNT_W     = 16;
  localparam int PSW_W     = 3;
  localparam int EVT_W     = 2;
  localparam int OSC_SEL_W = 3;
  localparam int PC_W      = 16;

  // ==========================================================
  // Register offsets
  localparam logic [AW-1:0] OFS_REQ      = 4'h0;
  localparam logic [AW-1:0] OFS_MASK     = 4'h1;
  localparam logic [AW-1:0] OFS_PRIO_LO  = 4'h2;
  localparam logic [AW-1:0] OFS_PRIO_HI  = 4'h3;
  localparam logic [AW-1:0] OFS_PSW      = 4'h4;
  localparam logic [AW-1:0] OFS_OSC      = 4'h5;
  localparam logic [AW-1:0] OFS_EVT_STAT = 4'h6;
  localparam logic [AW-1:0] OFS_EVT_MASK = 4'h7;
  localparam logic [AW-1:0] OFS_ACK_SRC  = 4'h8;

  // ==========================================================
  // Field positions and reset values
  localparam int PSW_IE_BIT     = 0;
  localparam int PSW_IN_SERVICE_PRIORITY_LO_BIT   = 1;
  localparam int PSW_IN_SERVICE_PRIORITY_HI_BIT   = 2;
  localparam int EVT_ACCEPT_BIT = 0;
  localparam int EVT_WAKE_BIT   = 1;

  localparam logic [N_SRC-1:0]     REQ_RST   = 8'h00;
  localparam logic [N_SRC-1:0]     MASK_RST  = 8'hff;
  localparam logic [N_SRC-1:0]     PRIO_RST  = 8'hff;
  localparam logic [PSW_W-1:0]     PSW_RST   = 3'h6;
  localparam logic [OSC_SEL_W-1:0] OSC_RST   = 3'h0;
  localparam logic [EVT_W-1:0]     EVT_RST   = 2'h0;
  localparam logic [1:0]           ISP_IDLE  = 2'h3;
  localparam logic [PC_W-1:0]      VEC_BASE  = 16'h0004;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int LAT_MIN_CLK   = 9;
  localparam int LAT_MAX_CLK   = 14;
  localparam int HALT_MIN_NS   = 61000;
  localparam int REL_VEC_CLK   = 10;
  localparam int REL_NOVEC_CLK = 5;

  // Flag latching takes one cycle and the first push is visible one cycle after the decision
  localparam logic [CNT_W-1:0] LAT_MIN_CNT  = 16'(LAT_MIN_CLK - 2);
  localparam logic [CNT_W-1:0] LAT_MAX_CNT  = 16'(LAT_MAX_CLK - 2);
  localparam logic [CNT_W-1:0] HALT_MIN_CYC =
    16'((HALT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] REL_VEC_LAST   = 16'(REL_VEC_CLK - 1);
  localparam logic [CNT_W-1:0] REL_NOVEC_LAST = 16'(REL_NOVEC_CLK - 1);

  // ==========================================================
  // State types
  typedef enum logic [1:0] {
    SVC_IDLE     = 2'b00,
    SVC_PUSH_PSW = 2'b01,
    SVC_PUSH_PC  = 2'b10,
    SVC_VECTOR   = 2'b11
  } mia_svc_t;

  typedef enum logic [1:0] {
    STP_RUN     = 2'b00,
    STP_STOPPED = 2'b01,
    STP_OSC     = 2'b10,
    STP_REL     = 2'b11
  } mia_stop_t;

endpackage

`default_nettype wire

/* hdl/mia_top.sv */
// Design decisions made here: the strobed register port and the placing of the registers.
`default_nettype none

module mia_top import mia_pkg::*; #(
  parameter logic [CNT_W-1:0] OSC_BASE_CYC = 16'h0100
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [AW-1:0]    reg_addr_i,
  input  wire logic [DW-1:0]    reg_wdata_i,
  input  wire logic             reg_we_i,
  input  wire logic             reg_re_i,
  output logic [DW-1:0]         reg_rdata_o,
  input  wire logic [N_SRC-1:0] req_set_i,
  input  wire logic             instr_boundary_i,
  input  wire logic             ret_exec_i,
  input  wire logic             return_from_interrupt_instr_i,
  input  wire logic [PSW_W-1:0] return_from_interrupt_instr_psw_i,
  input  wire logic [PC_W-1:0]  pc_i,
  input  wire logic             stop_enter_i,
  output logic                  push_valid_o,
  output logic [PC_W-1:0]       push_data_o,
  output logic                  vec_load_o,
  output logic [PC_W-1:0]       vec_addr_o,
  output logic                  halt_o,
  output logic                  irq_o
);

  // ==========================================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // State
  logic [N_SRC-1:0]     req_flag;
  logic [N_SRC-1:0]     interrupt_mask_flag;
  logic [N_SRC-1:0]     prio_lo;
  logic [N_SRC-1:0]     prio_hi;
  logic [PSW_W-1:0]     processor_status_word;
  logic [OSC_SEL_W-1:0] osc_stabilization_select;
  logic [EVT_W-1:0]     evt_stat;
  logic [EVT_W-1:0]     evt_mask;
  logic [IDX_W-1:0]     ack_idx;
  logic                 rel_vec;
  mia_svc_t             svc_state;
  mia_svc_t             next_svc_state;
  mia_stop_t            stop_state;
  mia_stop_t            next_stop_state;

  // ==========================================================
  // Register decode
  wire wr_req  = reg_we_i && (reg_addr_i == OFS_REQ);
  wire wr_mask = reg_we_i && (reg_addr_i == OFS_MASK);
  wire wr_plo  = reg_we_i && (reg_addr_i == OFS_PRIO_LO);
  wire wr_phi  = reg_we_i && (reg_addr_i == OFS_PRIO_HI);
  wire wr_psw  = reg_we_i && (reg_addr_i == OFS_PSW);
  wire wr_osc  = reg_we_i && (reg_addr_i == OFS_OSC);
  wire wr_est  = reg_we_i && (reg_addr_i == OFS_EVT_STAT);
  wire wr_emk  = reg_we_i && (reg_addr_i == OFS_EVT_MASK);

  // ==========================================================
  // Candidate selection
  wire                 global_int_enable      = processor_status_word[PSW_IE_BIT];
  wire                 in_service_priority_hi = processor_status_word[PSW_IN_SERVICE_PRIORITY_HI_BIT];
  wire                 in_service_priority_lo = processor_status_word[PSW_IN_SERVICE_PRIORITY_LO_BIT];
  wire [1:0]           isp = {in_service_priority_hi, in_service_priority_lo};
  wire [N_SRC-1:0]     pend = req_flag & ~interrupt_mask_flag;
  wire                 cand_valid;
  wire [IDX_W-1:0]     cand_idx;
  wire [1:0]           cand_lvl;

  mia_arbiter u_arb (
    .pend_i   (pend),
    .lvl_lo_i (prio_lo),
    .lvl_hi_i (prio_hi),
    .valid_o  (cand_valid),
    .idx_o    (cand_idx),
    .lvl_o    (cand_lvl)
  );

  // Same level as the one in service is held back as well
  wire lvl_ok   = (isp == ISP_IDLE) || (cand_lvl < isp);
  wire eligible = cand_valid && global_int_enable && lvl_ok;

  // ==========================================================
  // Acceptance latency
  wire [CNT_W-1:0] lat_cnt;
  wire             lat_clr = !((svc_state == SVC_IDLE) && eligible);

  mia_counter #(.W(CNT_W)) u_lat (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .clr_i   (lat_clr),
    .en_i    (1'b1),
    .cnt_o   (lat_cnt)
  );

  // A return in flight defers the decision even past the maximum
  wire start = (svc_state == SVC_IDLE) && eligible && !halt_o && !ret_exec_i
             && (lat_cnt >= LAT_MIN_CNT)
             && (instr_boundary_i || (lat_cnt >= LAT_MAX_CNT));

  // ==========================================================
  // Service sequence
  always_comb begin
    case (svc_state)
      SVC_IDLE:     next_svc_state = start ? SVC_PUSH_PSW : SVC_IDLE;
      SVC_PUSH_PSW: next_svc_state = SVC_PUSH_PC;
      SVC_PUSH_PC:  next_svc_state = SVC_VECTOR;
      SVC_VECTOR:   next_svc_state = SVC_IDLE;
      default:      next_svc_state = SVC_IDLE;
    endcase
  end

  wire [PC_W-1:0] next_push_data =
    (next_svc_state == SVC_PUSH_PSW) ? {13'h0000, processor_status_word} :
    (next_svc_state == SVC_PUSH_PC)  ? pc_i : 16'h0000;
  wire [PC_W-1:0] vec_addr = VEC_BASE + {12'h000, ack_idx, 1'b0};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      svc_state    <= SVC_IDLE;
      ack_idx      <= '0;
      push_valid_o <= 1'b0;
      push_data_o  <= '0;
      vec_load_o   <= 1'b0;
      vec_addr_o   <= '0;
    end else begin
      svc_state    <= next_svc_state;
      push_valid_o <= (next_svc_state == SVC_PUSH_PSW) || (next_svc_state == SVC_PUSH_PC);
      push_data_o  <= next_push_data;
      vec_load_o   <= (next_svc_state == SVC_VECTOR);
      vec_addr_o   <= (next_svc_state == SVC_VECTOR) ? vec_addr : 16'h0000;
      if (start) begin
        ack_idx <= cand_idx;
      end
    end
  end

  // ==========================================================
  // Status word
  logic [PSW_W-1:0] next_psw;

  always_comb begin
    next_psw = processor_status_word;
    if (start) begin
      next_psw[PSW_IE_BIT]   = 1'b0;
      next_psw[PSW_IN_SERVICE_PRIORITY_HI_BIT] = cand_lvl[1];
      next_psw[PSW_IN_SERVICE_PRIORITY_LO_BIT] = cand_lvl[0];
    end else if (return_from_interrupt_instr_i) begin
      next_psw = return_from_interrupt_instr_psw_i;
    end else if (wr_psw) begin
      next_psw = reg_wdata_i[PSW_W-1:0];
    end
  end

  // ==========================================================
  // Request flags: a new event beats either clear
  wire [N_SRC-1:0] ack_clr  = start ? (8'h01 << cand_idx) : 8'h00;
  wire [N_SRC-1:0] sw_clr   = wr_req ? reg_wdata_i : 8'h00;
  wire [N_SRC-1:0] next_req = (req_flag & ~sw_clr & ~ack_clr) | req_set_i;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_flag                 <= REQ_RST;
      interrupt_mask_flag      <= MASK_RST;
      prio_lo                  <= PRIO_RST;
      prio_hi                  <= PRIO_RST;
      processor_status_word    <= PSW_RST;
      osc_stabilization_select <= OSC_RST;
    end else begin
      req_flag              <= next_req;
      processor_status_word <= next_psw;
      if (wr_mask) begin
        interrupt_mask_flag <= reg_wdata_i;
      end
      if (wr_plo) begin
        prio_lo <= reg_wdata_i;
      end
      if (wr_phi) begin
        prio_hi <= reg_wdata_i;
      end
      if (wr_osc) begin
        osc_stabilization_select <= reg_wdata_i[OSC_SEL_W-1:0];
      end
    end
  end

  // ==========================================================
  // Stop release
  wire [CNT_W-1:0] wait_cnt;
  wire             wake_pend  = |pend;
  wire [CNT_W-1:0] osc_cyc    = OSC_BASE_CYC << osc_stabilization_select;
  wire [CNT_W-1:0] osc_target = (osc_cyc <= HALT_MIN_CYC) ? HALT_MIN_CYC : osc_cyc;
  wire [CNT_W-1:0] osc_last   = osc_target - 16'h0001;
  wire [CNT_W-1:0] rel_last   = rel_vec ? REL_VEC_LAST : REL_NOVEC_LAST;

  always_comb begin
    case (stop_state)
      STP_RUN:     next_stop_state = stop_enter_i ? STP_STOPPED : STP_RUN;
      STP_STOPPED: next_stop_state = wake_pend ? STP_OSC : STP_STOPPED;
      STP_OSC:     next_stop_state = (wait_cnt >= osc_last) ? STP_REL : STP_OSC;
      STP_REL:     next_stop_state = (wait_cnt >= rel_last) ? STP_RUN : STP_REL;
      default:     next_stop_state = STP_RUN;
    endcase
  end

  mia_counter #(.W(CNT_W)) u_wait (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .clr_i   (stop_state != next_stop_state),
    .en_i    (1'b1),
    .cnt_o   (wait_cnt)
  );

  wire wake_done = (stop_state == STP_REL) && (next_stop_state == STP_RUN);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stop_state <= STP_RUN;
      halt_o     <= 1'b0;
      rel_vec    <= 1'b0;
    end else begin
      stop_state <= next_stop_state;
      halt_o     <= (next_stop_state != STP_RUN);
      if ((stop_state == STP_OSC) && (next_stop_state == STP_REL)) begin
        rel_vec <= eligible;
      end
    end
  end

  // ==========================================================
  // Event status and interrupt line
  wire [EVT_W-1:0] evt_set       = {wake_done, start};
  wire [EVT_W-1:0] evt_clr       = wr_est ? reg_wdata_i[EVT_W-1:0] : 2'h0;
  wire [EVT_W-1:0] next_evt_stat = (evt_stat & ~evt_clr) | evt_set;
  wire [EVT_W-1:0] next_evt_mask = wr_emk ? reg_wdata_i[EVT_W-1:0] : evt_mask;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      evt_stat <= EVT_RST;
      evt_mask <= EVT_RST;
      irq_o    <= 1'b0;
    end else begin
      evt_stat <= next_evt_stat;
      evt_mask <= next_evt_mask;
      irq_o    <= |(next_evt_stat & next_evt_mask);
    end
  end

  // ==========================================================
  // Read path; unmapped offsets read zero
  wire [DW-1:0] rd_mux =
    (reg_addr_i == OFS_REQ)      ? req_flag :
    (reg_addr_i == OFS_MASK)     ? interrupt_mask_flag :
    (reg_addr_i == OFS_PRIO_LO)  ? prio_lo :
    (reg_addr_i == OFS_PRIO_HI)  ? prio_hi :
    (reg_addr_i == OFS_PSW)      ? {5'h00, processor_status_word} :
    (reg_addr_i == OFS_OSC)      ? {5'h00, osc_stabilization_select} :
    (reg_addr_i == OFS_EVT_STAT) ? {6'h00, evt_stat} :
    (reg_addr_i == OFS_EVT_MASK) ? {6'h00, evt_mask} :
    (reg_addr_i == OFS_ACK_SRC)  ? {5'h00, ack_idx} : 8'h00;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_re_i ? rd_mux : 8'h00;
    end
  end

endmodule

`default_nettype wire

/* verification/mia_core_model.sv */
`default_nettype none
// ==========================================================
// Core side: boundaries, PC, capture of stacked words and vector
module mia_core_model import mia_pkg::*; (
  input  wire logic            clk_i,
  input  wire logic            slow_i,
  input  wire logic            push_valid_i,
  input  wire logic [PC_W-1:0] push_data_i,
  input  wire logic            vec_load_i,
  input  wire logic [PC_W-1:0] vec_addr_i,
  output logic                 boundary_o,
  output logic [PC_W-1:0]      pc_o,
  output logic [PC_W-1:0]      psw_word_o,
  output logic [PC_W-1:0]      pc_word_o,
  output logic [PC_W-1:0]      vec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase  = 2'h0;
  logic       second = 1'b0;
  // Slow mode runs three-cycle instructions, stretching the wait for a boundary
  assign boundary_o = !slow_i || phase == 2'h2;
  initial pc_o = 16'h1000;
  always @(posedge clk_i) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    // PC frozen while stacking so the pushed value is well defined
    if (boundary_o && !push_valid_i) pc_o <= pc_o + 16'h0002;
    if (push_valid_i) second <= !second;
    if (push_valid_i && !second) psw_word_o <= push_data_i;
    if (push_valid_i && second) pc_word_o <= push_data_i;
    if (vec_load_i) vec_o <= vec_addr_i;
  end
endmodule
`default_nettype wire

/* verification/mia_props.sv */
`default_nettype none
module mia_props import mia_pkg::*; (
  input wire logic            clk_i,
  input wire logic            resetn_i,
  input wire logic            ret_exec_i,
  input wire logic            stop_enter_i,
  input wire logic            push_valid_o,
  input wire logic [PC_W-1:0] push_data_o,
  input wire logic            vec_load_o,
  input wire logic [PC_W-1:0] vec_addr_o,
  input wire logic            halt_o
);
  // ==========================================================
  // Halt length counter
  logic [CNT_W-1:0] halt_cnt;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) halt_cnt <= '0;
    else halt_cnt <= halt_o ? halt_cnt + 16'h0001 : '0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Service sequence
  a_push_pair: assert property ($rose(push_valid_o) |=> push_valid_o ##1 !push_valid_o)
    else $error("push not two words");
  a_psw_first: assert property ($rose(push_valid_o) |-> push_data_o[PC_W-1:PSW_W] == '0
    && push_data_o[PSW_IE_BIT]) else $error("first word not an enabled status word");
  a_vec_follow: assert property ($fell(push_valid_o) |-> vec_load_o)
    else $error("vector load missing after pushes");
  a_vec_single: assert property (vec_load_o |=> !vec_load_o && !push_valid_o)
    else $error("vector load longer than one cycle");
  a_vec_range: assert property (vec_load_o |-> vec_addr_o[0] == 1'b0
    && vec_addr_o >= VEC_BASE && vec_addr_o <= VEC_BASE + 16'h000e)
    else $error("vector address out of table");
  a_ret_block: assert property ($rose(push_valid_o) |-> !$past(ret_exec_i))
    else $error("accepted during subroutine return");
  // ==========================================================
  // Stop mode
  a_halt_entry: assert property ($rose(halt_o) |-> $past(stop_enter_i))
    else $error("halt without stop entry");
  a_halt_min: assert property ($fell(halt_o) |-> halt_cnt >= HALT_MIN_CYC)
    else $error("halt released too early");
  c_push: cover property ($rose(push_valid_o));
  c_vec: cover property (vec_load_o);
  c_wake: cover property ($fell(halt_o));
endmodule
bind mia_top mia_props u_props (
  .clk_i(clk_i), .resetn_i(resetn_i), .ret_exec_i(ret_exec_i), .stop_enter_i(stop_enter_i),
  .push_valid_o(push_valid_o), .push_data_o(push_data_o), .vec_load_o(vec_load_o),
  .vec_addr_o(vec_addr_o), .halt_o(halt_o));
`default_nettype wire

/* verification/mia_top_tb.sv */
`default_nettype none
module mia_top_tb import mia_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0, resetn = 1'b0, we = 1'b0, re = 1'b0, slow = 1'b0;
  logic             retx = 1'b0, return_from_interrupt_instr = 1'b0, stp = 1'b0, pv, vl, halt, irq, bnd;
  logic [AW-1:0]    addr = '0;
  logic [DW-1:0]    wdata = '0, rdata, d, lo, hi;
  logic [N_SRC-1:0] req = '0;
  logic [PSW_W-1:0] rpsw = '0;
  logic [PC_W-1:0]  pd, va, pc, psw_w, pc_w, vec_w;
  logic [16:0]      lf = 17'h11b86;
  int               n_mismatch = 0, num_checks = 0, n, w;
  localparam logic [7:0] RV [9] = '{REQ_RST, MASK_RST, PRIO_RST, PRIO_RST, 8'(PSW_RST),
                                    8'(OSC_RST), 8'(EVT_RST), 8'(EVT_RST), 8'h00};
  initial forever #20 clk = ~clk;
  mia_top #(.OSC_BASE_CYC(16'h0010)) uut (.clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .req_set_i(req),
    .instr_boundary_i(bnd), .ret_exec_i(retx), .return_from_interrupt_instr_i(return_from_interrupt_instr), .return_from_interrupt_instr_psw_i(rpsw), .pc_i(pc),
    .stop_enter_i(stp), .push_valid_o(pv), .push_data_o(pd), .vec_load_o(vl),
    .vec_addr_o(va), .halt_o(halt), .irq_o(irq));
  mia_core_model u_core (.clk_i(clk), .slow_i(slow), .push_valid_i(pv), .push_data_i(pd),
    .vec_load_i(vl), .vec_addr_i(va), .boundary_o(bnd), .pc_o(pc), .psw_word_o(psw_w),
    .pc_word_o(pc_w), .vec_o(vec_w));
  // ==========================================================
  // Helpers
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // Reference arbiter: best level, ties to the lowest index
  function automatic int win(input logic [7:0] p);
    int b = -1;
    int bl = 4;
    for (int i = 0; i < N_SRC; i++) begin
      if (p[i] && int'({hi[i], lo[i]}) < bl) begin
        b = i;
        bl = int'({hi[i], lo[i]});
      end
    end
    return b;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  // Pulses requests, then counts edges until the first stacked word or lim
  task automatic fire(input logic [7:0] m, input int lim);
    req <= m;
    n = 0;
    do begin
      @(posedge clk);
      req <= '0;
      n++;
      #1;
    end while (pv !== 1'b1 && n < lim);
  endtask
  task automatic svc(input int s, input logic [2:0] old);
    logic [15:0] p;
    if (pv !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
    p = pc;
    repeat (3) @(posedge clk);
    #1;
    chk(psw_w, {13'h0, old});
    chk(pc_w, p);
    chk(vec_w, VEC_BASE + 16'(2 * s));
  endtask
  task automatic blocked(input logic [7:0] m, input logic [7:0] ps, input logic [7:0] s);
    wr(OFS_MASK, m);
    wr(OFS_PSW, ps);
    fire(s, 30);
    chk(16'(pv), 0);
  endtask
  task automatic stop_run(input logic [7:0] ps, input int wt);
    wr(OFS_EVT_STAT, 8'h03);
    wr(OFS_PSW, ps);
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    fire(8'h01, 4);
    chk(16'(halt), 1);
    n = 0;
    while (halt === 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
      #1;
    end
    if (n >= 3000) n_mismatch++;
    if (n >= 3000) print_verdict();
    chk(16'(n >= 1520 + wt && n <= 1530 + wt), 1);
    // Vectoring starts the cycle after release, before any register read
    if (wt == REL_VEC_CLK) begin
      fire(8'h00, 20);
      svc(0, 3'h7);
    end
    rd(OFS_EVT_STAT, d);
    chk(16'(d[EVT_WAKE_BIT]), 1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      rd((i == 8) ? 4'hf : 4'(i), d);
      chk(d, RV[i]);
    end
    $display("test reset values done");
    wr(OFS_MASK, 8'h00);
    for (int r = 0; r < 6; r++) begin
      lf = lfsr(lf);
      lo = lf[7:0];
      hi = lf[15:8];
      wr(OFS_PRIO_LO, lo);
      wr(OFS_PRIO_HI, hi);
      wr(OFS_EVT_MASK, 8'h01);
      wr(OFS_PSW, 8'h07);
      slow <= r[0];
      lf = lfsr(lf);
      w = win(lf[7:0] | 8'h01);
      fire(lf[7:0] | 8'h01, 40);
      if (r[0]) chk(16'(n >= 9 && n <= 14), 1);
      else chk(16'(n), 9);
      svc(w, 3'h7);
      chk(16'(irq), 1);
      rd(OFS_PSW, d);
      chk(d, {5'h0, hi[w], lo[w], 1'b0});
      rd(OFS_REQ, d);
      chk(d, (lf[7:0] | 8'h01) & ~(8'h01 << w));
      rd(OFS_ACK_SRC, d);
      chk(d, 8'(w));
      wr(OFS_EVT_MASK, 8'h00);
      #1 chk(16'(irq), 0);
      wr(OFS_REQ, 8'hff);
      wr(OFS_EVT_STAT, 8'h01);
      rpsw <= 3'h5;
      return_from_interrupt_instr <= 1'b1;
      @(posedge clk);
      return_from_interrupt_instr <= 1'b0;
      rd(OFS_PSW, d);
      chk(d, 8'h05);
    end
    slow <= 1'b0;
    $display("test random arbitration done");
    lo = 8'h01;
    hi = 8'h02;
    wr(OFS_PRIO_LO, lo);
    wr(OFS_PRIO_HI, hi);
    blocked(8'h00, 8'h06, 8'h01);
    wr(OFS_PSW, 8'h07);
    fire(8'h00, 20);
    svc(0, 3'h7);
    blocked(8'hff, 8'h07, 8'h01);
    wr(OFS_MASK, 8'h00);
    fire(8'h00, 20);
    svc(0, 3'h7);
    retx <= 1'b1;
    blocked(8'h00, 8'h07, 8'h01);
    retx <= 1'b0;
    fire(8'h00, 20);
    svc(0, 3'h7);
    blocked(8'h00, 8'h03, 8'h03);
    fire(8'h04, 20);
    svc(2, 3'h3);
    wr(OFS_REQ, 8'hff);
    $display("test blocking done");
    stop_run(8'h06, REL_NOVEC_CLK);
    wr(OFS_REQ, 8'hff);
    // Selection below the 61 us floor must still give the full halt
    wr(OFS_OSC, 8'h06);
    rd(OFS_OSC, d);
    chk(d, 8'h06);
    stop_run(8'h07, REL_VEC_CLK);
    $display("test stop release done");
    print_verdict();
  end
endmodule
`default_nettype wire
